// File: dsi_seq_pkg.sv
// Constants, types and device register map for the DSI port enable sequencer
package dsi_seq_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWR_TMO_US = 20;
    localparam int BUF_TMO_US = 500;
    localparam int LINK_EXTRA_US = 500;
    localparam logic [15:0] T_INIT_US_RST = 16'h0064;
    localparam logic [15:0] T_WAKE_US_RST = 16'h03E8;
    localparam logic [15:0] EQ_REF_MHZ = 16'h007D;

    // Own Wishbone register offsets (byte addresses)
    localparam logic [7:0] WB_CTRL = 8'h00;
    localparam logic [7:0] WB_PLL = 8'h04;
    localparam logic [7:0] WB_TIMING = 8'h08;
    localparam logic [7:0] WB_STATUS = 8'h0C;
    // Control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_PORT = 1;
    localparam int CTRL_TE_OOB = 2;
    localparam int CTRL_DUAL = 3;
    localparam int CTRL_WIDE = 4;
    localparam int CTRL_OLDPHY = 5;
    localparam int CTRL_CMODE = 6;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Device register map
    localparam logic [15:0] D_IO_MODE = 16'h0000;
    localparam logic [15:0] D_PWR = 16'h0004;
    localparam logic [15:0] D_CLK_GATE = 16'h0008;
    localparam logic [15:0] D_PHY_MISC = 16'h000C;
    localparam logic [15:0] D_LANE_RST = 16'h0010;
    localparam logic [15:0] D_LANE_LATCH = 16'h0014;
    localparam logic [15:0] D_COMMON_CLK = 16'h0018;
    localparam logic [15:0] D_INIT_ROLE = 16'h001C;
    localparam logic [15:0] D_TX_TIMING_ONE = 16'h0020;
    localparam logic [15:0] D_TX_TIMING_TWO = 16'h0024;
    localparam logic [15:0] D_BUF = 16'h0028;
    localparam logic [15:0] D_T_INIT = 16'h002C;
    localparam logic [15:0] D_T_WAKE = 16'h0030;
    localparam logic [15:0] D_UTIL_PIN = 16'h0034;
    localparam logic [15:0] D_SYNC = 16'h0038;
    localparam logic [15:0] D_FUNC = 16'h003C;
    localparam logic [15:0] D_LINK_CFG = 16'h0040;
    // Device field positions and values
    localparam logic [31:0] IO_MODE_DSI = 32'h0000_0001;
    localparam int PWR_STAT_POS = 16;
    localparam int LATCH_OPEN_POS = 13;
    localparam logic [31:0] LANE_RST_FORCE = 32'h0000_0001;
    localparam logic [31:0] LATCH_FORCE_OPEN = 32'h0000_0003;
    localparam logic [31:0] CLK_LEFT = 32'h0000_0001;
    localparam logic [31:0] CLK_RIGHT = 32'h0000_0002;
    localparam int WORD_DIV_POS = 2;
    localparam logic [31:0] WORD_DIV_8 = 32'h0000_0008;
    localparam int EQ_DIV_POS = 8;
    localparam logic [31:0] INIT_ROLE_VAL = 32'h0000_0001;
    localparam logic [31:0] EARLY_READY_VAL = 32'h0000_0002;
    localparam int MASTER_OFF_POS = 4;
    localparam logic [31:0] MASTER_OFF_VAL = 32'h0000_0001;
    localparam logic [31:0] BUF_ENABLE = 32'h8000_0000;
    localparam logic [31:0] BUF_IDLE = 32'h0000_0080;
    localparam logic [31:0] UTIL_IN_EN = 32'h8000_0001;
    localparam logic [31:0] SYNC_EN = 32'h0000_0010;
    localparam logic [31:0] FUNC_EN = 32'h8000_0000;
    localparam logic [31:0] LINK_READY = 32'h0000_0001;
    localparam int CMODE_POS = 1;

    // Sequence step encoding
    localparam int STEP_W = 5;
    localparam logic [4:0] STEP_LAST = 5'h17;
    localparam logic [4:0] STEP_AFTER_LATCH = 5'h0A;
    localparam int TMO_W = 20;

    typedef enum logic [2:0] {
        OP_NOP, OP_WR, OP_RMW, OP_POLL, OP_TEST
    } op_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_ISSUE = 4'b0010,
        S_WAIT = 4'b0100,
        S_EVAL = 4'b1000
    } seq_state_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_REQ = 3'b010,
        M_REL = 3'b100
    } mst_state_t;

endpackage

// File: dsi_reg_if.sv
// Register access carrier between sequencer and device access port
`timescale 1ns/1ns
interface dsi_reg_if;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;

    modport seq (output req, output we, output addr, output wdata,
        input rdata, input done);
    modport mst (input req, input we, input addr, input wdata,
        output rdata, output done);
endinterface

// File: dsi_reg_master.sv
// Four-phase request/acknowledge master toward the device register port
`timescale 1ns/1ns
module dsi_reg_master
    import dsi_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Sequencer side
    dsi_reg_if.mst bus,
    // Device register port
    output logic dev_req,
    output logic dev_we,
    output logic [15:0] dev_addr,
    output logic [31:0] dev_wdata,
    input wire logic [31:0] dev_rdata,
    input wire logic dev_ack
);
    mst_state_t state;
    logic ack_s1, ack_s2;
    logic [31:0] rd_s1, rd_s2;

    // Device answers arrive from another domain: two flops first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            rd_s1 <= 32'h0000_0000;
            rd_s2 <= 32'h0000_0000;
        end else begin
            ack_s1 <= dev_ack;
            ack_s2 <= ack_s1;
            rd_s1 <= dev_rdata;
            rd_s2 <= rd_s1;
        end
    end

    // Request held until ack, then released until ack falls
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= M_IDLE;
            dev_req <= 1'b0;
            dev_we <= 1'b0;
            dev_addr <= 16'h0000;
            dev_wdata <= 32'h0000_0000;
            bus.rdata <= 32'h0000_0000;
            bus.done <= 1'b0;
        end else begin
            bus.done <= 1'b0;
            unique case (state)
                M_IDLE: begin
                    if (bus.req) begin
                        dev_req <= 1'b1;
                        dev_we <= bus.we;
                        dev_addr <= bus.addr;
                        dev_wdata <= bus.wdata;
                        state <= M_REQ;
                    end
                end
                M_REQ: begin
                    if (ack_s2) begin
                        bus.rdata <= rd_s2; // Data held stable under ack
                        dev_req <= 1'b0;
                        state <= M_REL;
                    end
                end
                M_REL: begin
                    if (!ack_s2) begin
                        bus.done <= 1'b1;
                        state <= M_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // dsi_reg_master

// File: dsi_port_enable_sequencer.sv
// DSI port enable sequencer: Wishbone slave, step table and wait engine
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module dsi_port_enable_sequencer
    import dsi_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Device register port
    output logic dev_req,
    output logic dev_we,
    output logic [15:0] dev_addr,
    output logic [31:0] dev_wdata,
    input wire logic [31:0] dev_rdata,
    input wire logic dev_ack
);
    // Own registers
    logic [7:0] ctrl;
    logic [15:0] pll_8x_mhz;
    logic [15:0] t_init_us;
    logic [15:0] t_wake_us;
    logic busy, done_flag, err_flag;
    logic [STEP_W-1:0] fail_step;
    logic start;

    // Sequencer state
    seq_state_t state;
    logic [STEP_W-1:0] step;
    logic wr_phase;
    logic [31:0] rd_val;
    logic [TMO_W-1:0] us_cnt;
    logic [7:0] pre_cnt;
    logic step_restart;

    // Current step decode
    op_t cur_op;
    logic [15:0] cur_addr;
    logic [31:0] cur_data;
    logic [31:0] cur_mask;
    logic [TMO_W-1:0] cur_tmo;
    logic [31:0] eq_div;
    logic [31:0] clk_cfg;
    logic [31:0] pwr_bit;
    logic [31:0] buf_want;
    logic [31:0] cmode_val;
    logic [TMO_W-1:0] link_tmo;
    logic match;
    logic timed_out;

    dsi_reg_if rif ();

    dsi_reg_master u_master (
        .clk(clk),
        .rstn(rstn),
        .bus(rif),
        .dev_req(dev_req),
        .dev_we(dev_we),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_rdata(dev_rdata),
        .dev_ack(dev_ack)
    );

    // Wishbone write with byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign start = cyc_i && stb_i && we_i && !ack_o && adr_i == WB_CTRL
        && sel_i[0] && dat_i[CTRL_START] && !busy;

    // Single-cycle registered ack; unmapped reads give zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= 32'h0000_0000;
            if (cyc_i && stb_i && !we_i && !ack_o) begin
                unique case (adr_i)
                    WB_CTRL: dat_o <= {24'h000000, ctrl};
                    WB_PLL: dat_o <= {16'h0000, pll_8x_mhz};
                    WB_TIMING: dat_o <= {t_wake_us, t_init_us};
                    WB_STATUS: dat_o <= {19'h00000, fail_step, 5'h00,
                        err_flag, done_flag, busy};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration is frozen while a sequence runs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= CTRL_RST;
            pll_8x_mhz <= 16'h0000;
            t_init_us <= T_INIT_US_RST;
            t_wake_us <= T_WAKE_US_RST;
        end else if (cyc_i && stb_i && we_i && !ack_o && !busy) begin
            unique case (adr_i)
                WB_CTRL: begin
                    ctrl <= 8'(merge({24'h000000, ctrl}, dat_i, sel_i))
                        & 8'hFE;
                end
                WB_PLL: begin
                    pll_8x_mhz <= 16'(merge({16'h0000, pll_8x_mhz}, dat_i,
                        sel_i));
                end
                WB_TIMING: begin
                    {t_wake_us, t_init_us} <= merge({t_wake_us, t_init_us},
                        dat_i, sel_i);
                end
                default: ;
            endcase
        end
    end

    // Derived field values
    assign eq_div = {16'h0000, pll_8x_mhz / EQ_REF_MHZ};
    assign clk_cfg = CLK_LEFT | (ctrl[CTRL_WIDE] ? CLK_RIGHT : 32'h0)
        | (WORD_DIV_8 << WORD_DIV_POS) | (eq_div << EQ_DIV_POS);
    assign pwr_bit = ctrl[CTRL_PORT] ? 32'h0000_0002 : 32'h0000_0001;
    assign buf_want = ctrl[CTRL_OLDPHY] ? BUF_IDLE : 32'h0000_0000;
    assign cmode_val = {29'h0, ctrl[CTRL_CMODE +: 2], 1'b0};
    assign link_tmo = TMO_W'({t_wake_us, 1'b0}) + TMO_W'(LINK_EXTRA_US);

    // Step table in enable order: IO, PLL map, phy, transcoder
    always_comb begin
        cur_op = OP_NOP;
        cur_addr = 16'h0000;
        cur_data = 32'h0000_0000;
        cur_mask = 32'h0000_0000;
        cur_tmo = '0;
        unique case (step)
            5'h00: begin
                cur_op = OP_WR;
                cur_addr = D_IO_MODE;
                cur_data = IO_MODE_DSI;
            end
            5'h01: begin
                // Only the port request; lane 0 comes up with it
                cur_op = OP_RMW;
                cur_addr = D_PWR;
                cur_data = pwr_bit;
            end
            5'h02: begin
                cur_op = OP_POLL;
                cur_addr = D_PWR;
                cur_mask = pwr_bit << PWR_STAT_POS;
                cur_data = pwr_bit << PWR_STAT_POS;
                cur_tmo = TMO_W'(PWR_TMO_US);
            end
            5'h03: begin
                // Setting an already set bit leaves it gated
                cur_op = OP_RMW;
                cur_addr = D_CLK_GATE;
                cur_data = pwr_bit;
            end
            5'h04: begin
                cur_op = OP_TEST;
                cur_addr = D_PHY_MISC;
                cur_mask = 32'h1 << LATCH_OPEN_POS;
            end
            5'h05: begin
                cur_op = OP_RMW;
                cur_addr = D_PHY_MISC;
                cur_mask = 32'h1 << LATCH_OPEN_POS;
            end
            5'h06: begin
                cur_op = OP_WR;
                cur_addr = D_LANE_RST;
                cur_data = LANE_RST_FORCE;
            end
            5'h07: begin
                cur_op = OP_WR;
                cur_addr = D_LANE_LATCH;
                cur_data = LATCH_FORCE_OPEN;
            end
            5'h08: begin
                cur_op = OP_WR;
                cur_addr = D_LANE_LATCH;
            end
            5'h09: begin
                cur_op = OP_WR;
                cur_addr = D_LANE_RST;
            end
            5'h0A: begin
                cur_op = OP_WR;
                cur_addr = D_COMMON_CLK;
                cur_data = clk_cfg;
            end
            5'h0B: begin
                cur_op = OP_WR;
                cur_addr = D_INIT_ROLE;
                cur_data = INIT_ROLE_VAL;
            end
            5'h0C: begin
                cur_op = OP_WR;
                cur_addr = D_TX_TIMING_ONE;
                cur_data = EARLY_READY_VAL;
            end
            5'h0D: begin
                // Deskew bit 0 left clear
                cur_op = OP_WR;
                cur_addr = D_TX_TIMING_TWO;
                cur_data = MASTER_OFF_VAL << MASTER_OFF_POS;
            end
            5'h0E: begin
                cur_op = OP_RMW;
                cur_addr = D_BUF;
                cur_data = BUF_ENABLE;
            end
            5'h0F: begin
                cur_op = OP_POLL;
                cur_addr = D_BUF;
                cur_mask = BUF_IDLE;
                cur_data = buf_want;
                cur_tmo = TMO_W'(BUF_TMO_US);
            end
            5'h10: begin
                // Phy transition timings written from t_init_us and t_wake_us
                cur_op = OP_WR;
                cur_addr = D_T_INIT;
                cur_data = {16'h0000, t_init_us};
            end
            5'h11: begin
                cur_op = OP_WR;
                cur_addr = D_T_WAKE;
                cur_data = {16'h0000, t_wake_us};
            end
            5'h12: begin
                cur_op = (!ctrl[CTRL_PORT] && ctrl[CTRL_TE_OOB]) ?
                    OP_WR : OP_NOP;
                cur_addr = D_UTIL_PIN;
                cur_data = UTIL_IN_EN;
            end
            5'h13: begin
                cur_op = OP_WR;
                cur_addr = D_LINK_CFG;
            end
            5'h14: begin
                cur_op = ctrl[CTRL_DUAL] ? OP_RMW : OP_NOP;
                cur_addr = D_SYNC;
                cur_data = SYNC_EN;
            end
            5'h15: begin
                cur_op = OP_RMW;
                cur_addr = D_FUNC;
                cur_data = FUNC_EN;
            end
            5'h16: begin
                // Long wait covers serial lane wakeup from ULPS
                cur_op = OP_POLL;
                cur_addr = D_LINK_CFG;
                cur_mask = LINK_READY;
                cur_data = LINK_READY;
                cur_tmo = link_tmo;
            end
            5'h17: begin
                cur_op = (cmode_val != 32'h0) ? OP_WR : OP_NOP;
                cur_addr = D_LINK_CFG;
                cur_data = cmode_val;
            end
            default: cur_op = OP_NOP;
        endcase
    end

    assign match = (rd_val & cur_mask) == cur_data;
    assign timed_out = us_cnt >= cur_tmo;
    assign step_restart = (state == S_IDLE) || (state == S_EVAL &&
        !(cur_op == OP_POLL && !match) && !(cur_op == OP_RMW && !wr_phase));

    // Microsecond time base, restarted on each new step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt <= 8'h00;
            us_cnt <= '0;
        end else if (step_restart) begin
            pre_cnt <= 8'h00;
            us_cnt <= '0;
        end else if (pre_cnt == 8'(CYC_PER_US - 1)) begin
            pre_cnt <= 8'h00;
            if (us_cnt != '1) begin
                us_cnt <= us_cnt + 1'b1;
            end
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
    end

    // Request toward the access port
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rif.req <= 1'b0;
            rif.we <= 1'b0;
            rif.addr <= 16'h0000;
            rif.wdata <= 32'h0000_0000;
        end else begin
            rif.req <= state == S_ISSUE && cur_op != OP_NOP;
            rif.we <= cur_op == OP_WR || (cur_op == OP_RMW && wr_phase);
            rif.addr <= cur_addr;
            rif.wdata <= (cur_op == OP_WR) ? cur_data
                : ((rd_val & ~cur_mask) | cur_data);
        end
    end

    // Sequence walker
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= S_IDLE;
            step <= '0;
            wr_phase <= 1'b0;
            rd_val <= 32'h0000_0000;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start) begin
                        step <= '0;
                        wr_phase <= 1'b0;
                        state <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    if (cur_op == OP_NOP) begin
                        state <= S_EVAL;
                    end else begin
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (rif.done) begin
                        rd_val <= rif.rdata;
                        state <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    state <= S_ISSUE;
                    if (cur_op == OP_RMW && !wr_phase) begin
                        wr_phase <= 1'b1;
                    end else if (cur_op == OP_POLL && !match) begin
                        if (timed_out) begin
                            state <= S_IDLE;
                        end
                    end else if (cur_op == OP_TEST &&
                                 (rd_val & cur_mask) == 32'h0) begin
                        step <= STEP_AFTER_LATCH;
                    end else begin
                        wr_phase <= 1'b0;
                        if (step == STEP_LAST) begin
                            state <= S_IDLE;
                        end else begin
                            step <= step + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Status flags; a new start clears the previous outcome
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            done_flag <= 1'b0;
            err_flag <= 1'b0;
            fail_step <= '0;
        end else if (start) begin
            busy <= 1'b1;
            done_flag <= 1'b0;
            err_flag <= 1'b0;
            fail_step <= '0;
        end else if (state == S_EVAL) begin
            if (cur_op == OP_POLL && !match && timed_out) begin
                busy <= 1'b0;
                err_flag <= 1'b1;
                fail_step <= step;
            end else if (step == STEP_LAST &&
                         !(cur_op == OP_RMW && !wr_phase)) begin
                busy <= 1'b0;
                done_flag <= 1'b1;
            end
        end
    end
endmodule // dsi_port_enable_sequencer

// File: dsi_dev_model.sv
// Behavioural device model behind the sequencer's register port
`timescale 1ns/1ns
module dsi_dev_model
    import dsi_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk, input wire logic rstn,
    // Register port
    input wire logic dev_req, input wire logic dev_we,
    input wire logic [15:0] dev_addr, input wire logic [31:0] dev_wdata,
    output logic [31:0] dev_rdata, output logic dev_ack,
    // Bench knobs
    input wire logic [3:0] lag, input wire logic old_phy,
    input wire logic hang
);
    logic [31:0] r [0:16];
    logic [31:0] rd;
    logic [3:0] w;
    logic [4:0] a;
    assign a = dev_addr[6:2];
    // Idle data is scrambled so a late sample never matches by luck
    assign dev_rdata = dev_ack ? rd : ~rd;
    // Slow or prompt four-phase answer, register side effects
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dev_ack <= 1'b0;
            w <= 4'h0;
            rd <= 32'h0;
            foreach (r[i]) r[i] <= 32'h0;
            r[3] <= 32'h0000_2000; // Latches found open
            r[10] <= BUF_IDLE ^ {24'h0, old_phy, 7'h0};
            r[11] <= 32'h0000_0064;
            r[12] <= 32'h0000_03E8;
        end else if (!dev_req) begin
            dev_ack <= 1'b0;
            w <= 4'h0;
        end else if (!dev_ack && w < lag) begin
            w <= w + 4'h1;
        end else if (!dev_ack) begin
            dev_ack <= 1'b1;
            rd <= r[a];
            if (dev_we) case (a)
                1: r[1] <= dev_wdata | {14'h0, dev_wdata[1:0], 16'h0};
                10: r[10] <= dev_wdata[31] ? (dev_wdata & ~BUF_IDLE)
                    | {24'h0, old_phy, 7'h0} : dev_wdata;
                15: begin
                    // Link ready set at once by the enable write, unless hang
                    if (dev_wdata[31] && !hang) r[16] <= r[16] | LINK_READY;
                    r[15] <= dev_wdata;
                end
                16: r[16] <= dev_wdata | (r[16] & LINK_READY);
                default: r[a] <= dev_wdata;
            endcase
        end
    end
endmodule // dsi_dev_model

// File: dsi_seq_properties.sv
// Port checker for the DSI port enable sequencer
`timescale 1ns/1ns
module dsi_seq_checker
    import dsi_seq_pkg::*;
(
    // Clock, reset, bus
    input wire logic clk, input wire logic rstn, input wire logic cyc_i,
    input wire logic stb_i, input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Device port
    input wire logic dev_req, input wire logic dev_we,
    input wire logic [15:0] dev_addr, input wire logic [31:0] dev_wdata,
    input wire logic dev_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Bus answer is a single pulse, so data must be quiet without it
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack");
    idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("dat_o not zero");
    // Four-phase device port: hold, drop after ack, leave a gap
    req_hold_a: assert property (dev_req && !dev_ack |=> dev_req
        && $stable(dev_addr) && $stable(dev_we) && $stable(dev_wdata))
        else $error("request moved");
    req_drop_a: assert property ($rose(dev_ack) |-> ##[1:3] !dev_req)
        else $error("req stuck");
    ack_low_a: assert property (!dev_req && dev_ack |=> !dev_req)
        else $error("early request");
    req_gap_a: assert property ($fell(dev_req) |=> (!dev_req)[*2])
        else $error("requests too close");
    io_mode_a: assert property (dev_req && dev_we
        && dev_addr == D_IO_MODE |-> dev_wdata == IO_MODE_DSI)
        else $error("io mode value");
    no_aux_a: assert property (dev_req |-> dev_addr <= D_LINK_CFG)
        else $error("stray address");
    wb_cov: cover property (cyc_i && ack_o);
    dev_cov: cover property ($rose(dev_ack));
    func_cov: cover property (dev_req && dev_addr == D_FUNC);
endmodule // dsi_seq_checker

bind dsi_port_enable_sequencer dsi_seq_checker chk_u (.clk(clk), .rstn(rstn),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .dev_req(dev_req), .dev_we(dev_we), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_ack(dev_ack));

// File: dsi_port_enable_sequencer_bench.sv
// Self-checking bench for the DSI port enable sequencer
`timescale 1ns/1ns
module dsi_port_enable_sequencer_bench;
    import dsi_seq_pkg::*;
    logic clk = 0, rstn = 0, cyc_i = 0, stb_i = 0, we_i = 0, old_phy = 1;
    logic hang = 0, ack_o, dev_req, dev_we, dev_ack;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] lag = 4'h1;
    logic [31:0] dat_i = 32'h0, dat_o, dev_wdata, dev_rdata, rv;
    logic [15:0] dev_addr;
    logic [31:0] ex [0:16] = '{32'h1, 32'h0002_0002, 32'h2, 32'h0, 32'h0,
        32'h0, 32'h0823, 32'h1, 32'h2, 32'h10, 32'h8000_0080, 32'h2, 32'h3,
        32'h0, SYNC_EN, FUNC_EN, 32'h5};
    int failures = 0, compares = 0;
    time t0;
    always #4 clk = ~clk;
    dsi_port_enable_sequencer dut_u (.clk(clk), .rstn(rstn), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dev_req(dev_req),
        .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
        .dev_rdata(dev_rdata), .dev_ack(dev_ack));
    dsi_dev_model m (.clk(clk), .rstn(rstn), .dev_req(dev_req),
        .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
        .dev_rdata(dev_rdata), .dev_ack(dev_ack), .lag(lag),
        .old_phy(old_phy), .hang(hang));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    // One classic cycle; read data kept in rv
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk); while (ack_o !== 1'b1);
        rv = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk);
    endtask
    // Status polled over the bus until busy drops
    task wait_idle;
        do wb(1'b0, WB_STATUS, 32'h0); while (rv[0] !== 1'b0);
    endtask
    task close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        wb(1'b0, WB_TIMING, 32'h0);
        chk("timing reset", rv, 32'h03E8_0064);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", rv, 32'h0);
        wb(1'b1, WB_PLL, 32'h0000_03E8);
        wb(1'b1, WB_TIMING, 32'h0003_0002);
        // Port 1, dual, wide, older polarity, clock mode 2
        wb(1'b1, WB_CTRL, 32'h0000_00BB);
        wb(1'b1, WB_TIMING, 32'h0009_0009);
        wait_idle();
        chk("status done", rv, 32'h2);
        wb(1'b0, WB_TIMING, 32'h0);
        chk("busy write", rv, 32'h0003_0002);
        for (int i = 0; i <= 16; i++)
            chk($sformatf("dev reg %0d", i), m.r[i], ex[i]);
        // Second run: port 0, slow device, link never ready
        rstn <= 1'b0;
        old_phy <= 1'b0;
        hang <= 1'b1;
        lag <= 4'h5;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        wb(1'b1, WB_PLL, 32'h0000_03E8);
        wb(1'b1, WB_TIMING, 32'h0003_0002);
        wb(1'b1, WB_CTRL, 32'h0000_0005);
        // Span counted from the function enable landing, not from start
        wait (m.r[15][31] === 1'b1);
        t0 = $time;
        wait_idle();
        chk("status fail", rv, 32'h0000_1604);
        chk("wait span", 32'(($time - t0) / US_NS), 32'd506);
        chk("util pin", m.r[13], UTIL_IN_EN);
        chk("power a", m.r[1], 32'h0001_0001);
        chk("clock cfg", m.r[6], 32'h0821);
        chk("no sync", m.r[14], 32'h0);
        chk("no mode", m.r[16], 32'h0);
        close_out();
    end
    // Hang guard sized above both runs
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule // dsi_port_enable_sequencer_bench
